// ---- rtl/fcpwm_pkg.sv ----
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package fcpwm_pkg;

   localparam int FCPWM_NCH = 4;
   localparam int FCPWM_CW = 12;
   localparam int FCPWM_DW = 8;

   // Register byte offsets.
   localparam logic [7:0] FCPWM_CFG_OFS = 8'h00;
   localparam logic [7:0] FCPWM_CHOP_OFS = 8'h04;
   localparam logic [7:0] FCPWM_DEAD_OFS = 8'h08;
   localparam logic [7:0] FCPWM_PLEN_OFS = 8'h0c;
   localparam logic [7:0] FCPWM_TRIG_OFS = 8'h10;
   localparam logic [7:0] FCPWM_STAT_OFS = 8'h14;
   localparam logic [7:0] FCPWM_DUTY_OFS = 8'h20;

   // Field positions.
   localparam int FCPWM_CFG_ALIGN_LSB = 12;
   localparam int FCPWM_CFG_POL_LSB = 14;
   localparam int FCPWM_DEAD_HS_LSB = 8;
   localparam int FCPWM_HI_LSB = 16;

   // Reset values.
   localparam logic [11:0] FCPWM_MAX_RST = 12'hfff;
   localparam logic [7:0] FCPWM_DEAD_RST = 8'h00;
   localparam logic [7:0] FCPWM_PLEN_RST = 8'h01;

   // Alignment codes.
   localparam logic [1:0] FCPWM_AL_LEFT = 2'h0;
   localparam logic [1:0] FCPWM_AL_CENTER = 2'h1;
   localparam logic [1:0] FCPWM_AL_RIGHT = 2'h2;

   // Chopper select codes.
   localparam logic [2:0] FCPWM_CH_LS_ON = 3'h1;
   localparam logic [2:0] FCPWM_CH_HS_ON = 3'h2;
   localparam logic [2:0] FCPWM_CH_LS_PWM = 3'h5;
   localparam logic [2:0] FCPWM_CH_HS_PWM = 3'h6;
   localparam logic [2:0] FCPWM_CH_COMPL = 3'h7;

   // Trigger indices.
   localparam int FCPWM_TR_ZERO = 0;
   localparam int FCPWM_TR_CENTER = 1;
   localparam int FCPWM_TR_A = 2;
   localparam int FCPWM_TR_B = 3;

   // Polarity bits: high side, low side, triggers.
   typedef struct packed {
      logic trig;
      logic ls;
      logic hs;
   } fcpwm_pol_t;

   // Software configuration.
   typedef struct packed {
      logic [11:0] max;
      logic [1:0] align;
      fcpwm_pol_t pol;
      logic [3:0][2:0] chop;
      logic [7:0] dead_ls;
      logic [7:0] dead_hs;
      logic [7:0] plen;
      logic [11:0] tpa;
      logic [11:0] tpb;
      logic [3:0][11:0] duty;
      logic [3:0][11:0] shift;
   } fcpwm_cfg_t;

   // Values held for a whole period.
   typedef struct packed {
      logic [11:0] max;
      logic [1:0] align;
      logic [11:0] tpa;
      logic [11:0] tpb;
      logic [3:0][11:0] duty;
      logic [3:0][11:0] shift;
   } fcpwm_shadow_t;

   // Requested switch state of one half bridge.
   typedef struct packed {
      logic hs;
      logic ls;
   } fcpwm_bridge_t;

endpackage

// ---- rtl/fcpwm_dead_time.sv ----
`timescale 1ns/1ps
module fcpwm_dead_time
   import fcpwm_pkg::*;
#(
   parameter int DW = FCPWM_DW
) (
   input wire logic pclk,
   input wire logic presetn,
   input fcpwm_bridge_t req,
   input wire logic [DW-1:0] dead_hs,
   input wire logic [DW-1:0] dead_ls,
   output fcpwm_bridge_t drv
);

   typedef struct packed {
      fcpwm_bridge_t drv;
      logic [DW-1:0] idle;
   } fcpwm_dt_state_t;

   fcpwm_dt_state_t st_r;
   fcpwm_dt_state_t st_nxt;

   // Turns a side off at once and turns a side on only after both have been off long enough.
   always_comb begin
      st_nxt = st_r;
      if (st_r.drv.hs && !req.hs) begin
         st_nxt.drv.hs = 1'b0;
         st_nxt.idle = '0;
      end
      if (st_r.drv.ls && !req.ls) begin
         st_nxt.drv.ls = 1'b0;
         st_nxt.idle = '0;
      end
      if (!st_r.drv.hs && !st_r.drv.ls) begin
         if (st_r.idle != {DW{1'b1}}) begin
            st_nxt.idle = st_r.idle + 1'b1;
         end
         if (req.hs && !req.ls && st_r.idle >= dead_hs) begin
            st_nxt.drv.hs = 1'b1;
         end else if (req.ls && !req.hs && st_r.idle >= dead_ls) begin
            st_nxt.drv.ls = 1'b1;
         end
      end
   end

   // Registers the state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign drv = st_r.drv;

endmodule

// ---- rtl/fcpwm_top.sv ----
`timescale 1ns/1ps
module fcpwm_top
   import fcpwm_pkg::*;
#(
   parameter int NCH = FCPWM_NCH
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [NCH-1:0] high_side_out,
   output logic [NCH-1:0] low_side_out,
   output logic cycle_start_trigger,
   output logic mid_cycle_trigger,
   output logic trigger_a,
   output logic trigger_b,
   output logic combined_programmable_trigger
);

   typedef struct packed {
      fcpwm_cfg_t cfg;
      fcpwm_shadow_t sh;
      logic [11:0] cnt;
      logic down;
      logic [3:0][7:0] pcnt;
      logic [3:0] req_hs;
      logic [3:0] req_ls;
      logic [3:0] hs_o;
      logic [3:0] ls_o;
      logic [3:0] trig_o;
      logic ab_o;
      logic [31:0] rdata;
   } fcpwm_state_t;

   fcpwm_state_t st_r;
   fcpwm_state_t st_nxt;
   fcpwm_bridge_t [NCH-1:0] dt_req;
   fcpwm_bridge_t [NCH-1:0] dt_drv;

   //---------------------------------------------------------------------------
   // Helper functions
   //---------------------------------------------------------------------------

   // Modulated level of one channel for the present counter position.
   function automatic logic pwm_level(input logic [11:0] cnt, input logic down,
                                      input fcpwm_shadow_t sh, input logic [11:0] duty,
                                      input logic [11:0] shift);
      logic [12:0] q;
      logic signed [14:0] thr_up;
      logic signed [14:0] thr_dn;
      logic lvl;
      q = '0;
      thr_up = '0;
      thr_dn = '0;
      lvl = 1'b0;
      if (cnt >= shift) begin
         q = {1'b0, cnt} - {1'b0, shift};
      end else begin
         q = {1'b0, cnt} + {1'b0, sh.max} + 13'h0001 - {1'b0, shift};
      end
      thr_up = $signed({3'h0, sh.max}) - $signed({3'h0, duty}) + $signed({3'h0, shift});
      thr_dn = $signed({3'h0, sh.max}) - $signed({3'h0, duty}) - $signed({3'h0, shift});
      case (sh.align)
         FCPWM_AL_CENTER: begin
            if (down) begin
               lvl = $signed({3'h0, cnt}) > thr_dn;
            end else begin
               lvl = $signed({3'h0, cnt}) > thr_up;
            end
         end
         FCPWM_AL_RIGHT: begin
            lvl = (q + {1'b0, duty}) > {1'b0, sh.max};
         end
         default: begin
            lvl = q < {1'b0, duty};
         end
      endcase
      return lvl;
   endfunction

   // Side requests for one chopper select code.
   function automatic fcpwm_bridge_t chop_req(input logic [2:0] mode, input logic lvl);
      fcpwm_bridge_t b;
      b = '0;
      case (mode)
         FCPWM_CH_LS_ON: b.ls = 1'b1;
         FCPWM_CH_HS_ON: b.hs = 1'b1;
         FCPWM_CH_LS_PWM: b.ls = lvl;
         FCPWM_CH_HS_PWM: b.hs = lvl;
         FCPWM_CH_COMPL: begin
            b.hs = lvl;
            b.ls = !lvl;
         end
         default: b = '0;
      endcase
      return b;
   endfunction

   // Read value for one byte address.
   function automatic logic [31:0] rd_word(input logic [7:0] a, input fcpwm_state_t s);
      logic [31:0] w;
      w = '0;
      case (a)
         FCPWM_CFG_OFS: w = {15'h0000, s.cfg.pol, s.cfg.align, s.cfg.max};
         FCPWM_CHOP_OFS: w = {20'h00000, s.cfg.chop};
         FCPWM_DEAD_OFS: w = {16'h0000, s.cfg.dead_hs, s.cfg.dead_ls};
         FCPWM_PLEN_OFS: w = {24'h000000, s.cfg.plen};
         FCPWM_TRIG_OFS: w = {4'h0, s.cfg.tpb, 4'h0, s.cfg.tpa};
         FCPWM_STAT_OFS: w = {19'h00000, s.down, s.cnt};
         default: begin
            for (int i = 0; i < NCH; i++) begin
               if (a == FCPWM_DUTY_OFS + 8'(4 * i)) begin
                  w = {4'h0, s.cfg.shift[i], 4'h0, s.cfg.duty[i]};
               end
            end
         end
      endcase
      return w;
   endfunction

   // True for any mapped byte address.
   function automatic logic addr_ok(input logic [7:0] a);
      logic ok;
      ok = (a <= FCPWM_STAT_OFS) && (a[1:0] == 2'h0);
      for (int i = 0; i < NCH; i++) begin
         if (a == FCPWM_DUTY_OFS + 8'(4 * i)) begin
            ok = 1'b1;
         end
      end
      return ok;
   endfunction

   //---------------------------------------------------------------------------
   // Next-state logic
   //---------------------------------------------------------------------------

   logic at_end;
   logic [3:0] ev;

   // Counter, shadows, channel requests, trigger pulses, polarity and bus access.
   always_comb begin
      st_nxt = st_r;
      at_end = 1'b0;
      ev = '0;

      // Register writes land in the access phase.
      if (psel && penable && pwrite) begin
         case (paddr)
            FCPWM_CFG_OFS: begin
               st_nxt.cfg.max = pwdata[11:0];
               st_nxt.cfg.align = pwdata[FCPWM_CFG_ALIGN_LSB +: 2];
               st_nxt.cfg.pol = pwdata[FCPWM_CFG_POL_LSB +: 3];
            end
            FCPWM_CHOP_OFS: st_nxt.cfg.chop = pwdata[11:0];
            FCPWM_DEAD_OFS: begin
               st_nxt.cfg.dead_ls = pwdata[7:0];
               st_nxt.cfg.dead_hs = pwdata[FCPWM_DEAD_HS_LSB +: 8];
            end
            FCPWM_PLEN_OFS: st_nxt.cfg.plen = pwdata[7:0];
            FCPWM_TRIG_OFS: begin
               st_nxt.cfg.tpa = pwdata[11:0];
               st_nxt.cfg.tpb = pwdata[FCPWM_HI_LSB +: 12];
            end
            default: begin
               for (int i = 0; i < NCH; i++) begin
                  if (paddr == FCPWM_DUTY_OFS + 8'(4 * i)) begin
                     st_nxt.cfg.duty[i] = pwdata[11:0];
                     st_nxt.cfg.shift[i] = pwdata[FCPWM_HI_LSB +: 12];
                  end
               end
            end
         endcase
      end

      // Read data is captured in the setup phase.
      if (psel && !penable) begin
         st_nxt.rdata = rd_word(paddr, st_r);
      end

      if (st_r.sh.align == FCPWM_AL_CENTER && st_r.sh.max > 12'h001) begin
         at_end = st_r.down && st_r.cnt == 12'h001;
      end else begin
         at_end = st_r.cnt >= st_r.sh.max;
      end

      if (at_end) begin
         st_nxt.cnt = '0;
         st_nxt.down = 1'b0;
         st_nxt.sh.max = st_nxt.cfg.max;
         st_nxt.sh.align = st_nxt.cfg.align;
         st_nxt.sh.tpa = st_nxt.cfg.tpa;
         st_nxt.sh.tpb = st_nxt.cfg.tpb;
         st_nxt.sh.duty = st_nxt.cfg.duty;
         st_nxt.sh.shift = st_nxt.cfg.shift;
      end else if (st_r.sh.align == FCPWM_AL_CENTER && !st_r.down &&
                   st_r.cnt == st_r.sh.max) begin
         st_nxt.down = 1'b1;
         st_nxt.cnt = st_r.cnt - 12'h001;
      end else if (st_r.down) begin
         st_nxt.cnt = st_r.cnt - 12'h001;
      end else begin
         st_nxt.cnt = st_r.cnt + 12'h001;
      end

      for (int i = 0; i < NCH; i++) begin
         {st_nxt.req_hs[i], st_nxt.req_ls[i]} = chop_req(st_r.cfg.chop[i],
            pwm_level(st_r.cnt, st_r.down, st_r.sh, st_r.sh.duty[i], st_r.sh.shift[i]));
      end

      ev[FCPWM_TR_ZERO] = st_r.cnt == 12'h000 && !st_r.down;
      if (st_r.sh.align == FCPWM_AL_CENTER) begin
         ev[FCPWM_TR_CENTER] = st_r.cnt == st_r.sh.max && !st_r.down;
      end else begin
         ev[FCPWM_TR_CENTER] = st_r.cnt == 12'((13'(st_r.sh.max) + 13'h0001) >> 1);
      end
      ev[FCPWM_TR_A] = st_r.cnt == st_r.sh.tpa && !st_r.down;
      ev[FCPWM_TR_B] = st_r.cnt == st_r.sh.tpb && !st_r.down;

      for (int t = 0; t < 4; t++) begin
         if (ev[t]) begin
            st_nxt.pcnt[t] = st_r.cfg.plen;
         end else if (st_r.pcnt[t] != 8'h00) begin
            st_nxt.pcnt[t] = st_r.pcnt[t] - 8'h01;
         end
         st_nxt.trig_o[t] = (st_nxt.pcnt[t] != 8'h00) ^ st_r.cfg.pol.trig;
      end
      st_nxt.ab_o = ((st_nxt.pcnt[FCPWM_TR_A] != 8'h00) ||
                     (st_nxt.pcnt[FCPWM_TR_B] != 8'h00)) ^ st_r.cfg.pol.trig;

      for (int i = 0; i < NCH; i++) begin
         st_nxt.hs_o[i] = dt_drv[i].hs ^ st_r.cfg.pol.hs;
         st_nxt.ls_o[i] = dt_drv[i].ls ^ st_r.cfg.pol.ls;
      end
   end

   //---------------------------------------------------------------------------
   // State register
   //---------------------------------------------------------------------------

   // Loads reset values, then the next state on every edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
         st_r.cfg.max <= FCPWM_MAX_RST;
         st_r.cfg.dead_ls <= FCPWM_DEAD_RST;
         st_r.cfg.dead_hs <= FCPWM_DEAD_RST;
         st_r.cfg.plen <= FCPWM_PLEN_RST;
         st_r.sh.max <= FCPWM_MAX_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   //---------------------------------------------------------------------------
   // Dead-time stages
   //---------------------------------------------------------------------------

   // One dead-time stage per channel, all fed by the shared dead-time values.
   for (genvar g = 0; g < NCH; g++) begin : g_dt
      assign dt_req[g].hs = st_r.req_hs[g];
      assign dt_req[g].ls = st_r.req_ls[g];
      fcpwm_dead_time #(
         .DW(FCPWM_DW)
      ) u_dt (
         .pclk(pclk),
         .presetn(presetn),
         .req(dt_req[g]),
         .dead_hs(st_r.cfg.dead_hs),
         .dead_ls(st_r.cfg.dead_ls),
         .drv(dt_drv[g])
      );
   end

   //---------------------------------------------------------------------------
   // Outputs
   //---------------------------------------------------------------------------

   // Bus answer is ready in the first access cycle.
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok(paddr);
   assign prdata = st_r.rdata;

   assign high_side_out = st_r.hs_o[NCH-1:0];
   assign low_side_out = st_r.ls_o[NCH-1:0];
   assign cycle_start_trigger = st_r.trig_o[FCPWM_TR_ZERO];
   assign mid_cycle_trigger = st_r.trig_o[FCPWM_TR_CENTER];
   assign trigger_a = st_r.trig_o[FCPWM_TR_A];
   assign trigger_b = st_r.trig_o[FCPWM_TR_B];
   assign combined_programmable_trigger = st_r.ab_o;

endmodule

// ---- verif/fcpwm_chk.sv ----
`timescale 1ns/1ps
//------------------------------------------------------------------------------
// Port checker
//------------------------------------------------------------------------------
module fcpwm_chk
   import fcpwm_pkg::*;
#(
   parameter int NCH = FCPWM_NCH
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [NCH-1:0] high_side_out,
   input wire logic [NCH-1:0] low_side_out,
   input wire logic cycle_start_trigger,
   input wire logic mid_cycle_trigger,
   input wire logic trigger_a,
   input wire logic trigger_b,
   input wire logic combined_programmable_trigger
);
   logic wr, st_on, st_rise, md_rise, last_hs_r, st_r, md_r;
   logic [NCH-1:0] on_hs, on_ls;
   logic [3:0] quiet_r;
   logic [2:0] pol_r;
   logic [1:0] align_r, starts_r;
   logic [11:0] max_r;
   logic [7:0] dl_r, dh_r, plen_r, run_r, off_r;
   logic [12:0] gap_r, per, half;

   // On-levels with polarity removed, and the expected period and midpoint.
   assign wr = psel && penable && pwrite && pready;
   assign on_hs = high_side_out ^ {NCH{pol_r[0]}};
   assign on_ls = low_side_out ^ {NCH{pol_r[1]}};
   assign st_on = cycle_start_trigger ^ pol_r[2];
   assign st_rise = st_on && !st_r;
   assign md_rise = (mid_cycle_trigger ^ pol_r[2]) && !md_r;
   assign per = (align_r == FCPWM_AL_CENTER && max_r > 12'h001) ? {max_r, 1'h0} :
                {1'h0, max_r} + 13'h0001;
   assign half = (align_r == FCPWM_AL_CENTER) ? {1'h0, max_r} : per >> 1;

   // Mirrors settings from bus writes and counts gaps and pulse runs.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quiet_r <= 4'h0;
         {pol_r, align_r, max_r} <= {5'h00, FCPWM_MAX_RST};
         {dh_r, dl_r} <= {FCPWM_DEAD_RST, FCPWM_DEAD_RST};
         plen_r <= FCPWM_PLEN_RST;
         starts_r <= 2'h0;
         gap_r <= 13'h0000;
         {run_r, off_r} <= 16'h0000;
         {last_hs_r, st_r, md_r} <= 3'h0;
      end else begin
         quiet_r <= wr ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hf};
         if (wr && paddr == FCPWM_CFG_OFS) begin
            {pol_r, align_r, max_r} <= pwdata[16:0];
         end
         if (wr && paddr == FCPWM_DEAD_OFS) begin
            {dh_r, dl_r} <= pwdata[15:0];
         end
         if (wr && paddr == FCPWM_PLEN_OFS) begin
            plen_r <= pwdata[7:0];
         end
         starts_r <= wr ? 2'h0 : starts_r + {1'h0, st_rise && starts_r != 2'h3};
         gap_r <= st_rise ? 13'h0001 : gap_r + 13'h0001;
         run_r <= st_on ? run_r + 8'h01 : 8'h00;
         off_r <= (on_hs[0] || on_ls[0]) ? 8'h00 : off_r + {7'h00, off_r != 8'hff};
         last_hs_r <= on_hs[0] ? 1'h1 : (on_ls[0] ? 1'h0 : last_hs_r);
         st_r <= st_on;
         md_r <= mid_cycle_trigger ^ pol_r[2];
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_comb_or_ab: assert property (quiet_r == 4'hf |-> combined_programmable_trigger ==
      (pol_r[2] ? trigger_a && trigger_b : trigger_a || trigger_b)) else $error("bad combined");
   chk_no_overlap: assert property (quiet_r == 4'hf |-> (on_hs & on_ls) == '0)
      else $error("both sides on");
   chk_dead_low: assert property (quiet_r == 4'hf && $rose(on_ls[0]) && last_hs_r
      |-> off_r > dl_r) else $error("low side on too early");
   chk_dead_high: assert property (quiet_r == 4'hf && $rose(on_hs[0]) && !last_hs_r
      |-> off_r > dh_r) else $error("high side on too early");
   chk_pulse_len: assert property (quiet_r == 4'hf && $fell(st_on) |-> run_r == plen_r)
      else $error("bad pulse length");
   chk_period_len: assert property (st_rise && starts_r == 2'h3 |-> gap_r == per)
      else $error("bad period");
   chk_mid_place: assert property (md_rise && starts_r == 2'h3 |-> gap_r == half)
      else $error("bad mid pulse place");
   chk_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("read data moved");
   chk_unmapped_err: assert property (psel && penable && paddr == 8'h18 |-> pslverr)
      else $error("no error on unmapped");
endmodule

// ---- verif/fcpwm_gate_model.sv ----
`timescale 1ns/1ps
//------------------------------------------------------------------------------
// Half-bridge gate driver model
//------------------------------------------------------------------------------
module fcpwm_gate_model (
   input wire logic pclk,
   input wire logic watch_en,
   input wire logic [3:0] hs_on,
   input wire logic [3:0] ls_on,
   output int shoot_cnt
);
   int shoot_r = 0;

   // Counts cycles in which a bridge conducts through both switches.
   always @(posedge pclk) begin
      if (watch_en && (hs_on & ls_on) != 4'h0) begin
         shoot_r <= shoot_r + 1;
      end
   end

   // Hands the count to the bench.
   assign shoot_cnt = shoot_r;
endmodule

// ---- verif/fcpwm_bench.sv ----
`timescale 1ns/1ps
//------------------------------------------------------------------------------
// Bench for the four-channel modulator
//------------------------------------------------------------------------------
module fcpwm_bench
   import fcpwm_pkg::*;
;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic watch_en = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, cst, mct, tra, trb, ctr, e;
   logic [3:0] hso, lso;
   logic [2:0] pol = 3'h0;
   int n_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int shoot, d, dd;
   int hc[4], lc[4], tc[5];

   // Clock of 10 ns period.
   always #5 pclk = ~pclk;

   fcpwm_top #(.NCH(4)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .high_side_out(hso), .low_side_out(lso), .cycle_start_trigger(cst),
      .mid_cycle_trigger(mct), .trigger_a(tra), .trigger_b(trb),
      .combined_programmable_trigger(ctr)
   );
   fcpwm_gate_model gates (
      .pclk(pclk), .watch_en(watch_en), .hs_on(hso ^ {4{pol[0]}}),
      .ls_on(lso ^ {4{pol[1]}}), .shoot_cnt(shoot)
   );

   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // One bus transfer; the request is held until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // Counts on-cycles of every gate and high cycles of every trigger over n cycles.
   task automatic watch(input int n);
      hc = '{default: 0};
      lc = '{default: 0};
      tc = '{default: 0};
      repeat (n) begin
         @(negedge pclk);
         foreach (hc[i]) begin
            hc[i] += hso[i] ^ pol[0];
            lc[i] += lso[i] ^ pol[1];
         end
         tc[0] += cst;
         tc[1] += mct;
         tc[2] += tra;
         tc[3] += trb;
         tc[4] += ctr;
      end
   endtask

   // Cycles from a start pulse to the next rise of a selected output.
   task automatic phase(input int sel);
      logic [3:0] s;
      @(negedge pclk);
      while (cst !== 1'h0) @(negedge pclk);
      while (cst !== 1'h1) @(negedge pclk);
      d = 0;
      for (int k = 1; k >= 0; k--) begin
         s = {mct, trb, tra, hso[0] ^ pol[0]};
         while (s[sel] === k[0]) begin
            @(negedge pclk);
            d++;
            s = {mct, trb, tra, hso[0] ^ pol[0]};
         end
      end
   endtask

   // Cuts a hung run short.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         n_errors++;
         stop_test();
      end
   end

   // Main sequence.
   initial begin
      repeat (8) @(posedge pclk);
      check({hso, lso, cst, mct, tra, trb, ctr}, 32'h0);
      presetn <= 1'h1;
      watch_en <= 1'h1;
      apb(1'h0, FCPWM_CFG_OFS, 32'h0);
      check(q, 32'h0000_0fff);
      apb(1'h0, FCPWM_PLEN_OFS, 32'h0);
      check(q, 32'h1);
      apb(1'h0, FCPWM_DEAD_OFS, 32'h0);
      check(q, 32'h0);
      apb(1'h0, 8'h18, 32'h0);
      check(q, 32'h0);
      check(e, 32'h1);
      $display("test registers done");
      apb(1'h1, FCPWM_CFG_OFS, 32'h9);
      apb(1'h1, FCPWM_PLEN_OFS, 32'h2);
      apb(1'h1, FCPWM_TRIG_OFS, 32'h0006_0002);
      apb(1'h1, FCPWM_DEAD_OFS, 32'h0102);
      for (int i = 0; i < 4; i++) apb(1'h1, FCPWM_DUTY_OFS + 8'(4 * i), 32'(i + 3));
      // The reset period is a full-length one; the new period, alignment, trigger and duty settings only act after its end.
      repeat (int'(FCPWM_MAX_RST) + 4) @(posedge pclk);
      for (int m = 0; m < 8; m++) begin
         apb(1'h1, FCPWM_CHOP_OFS, 32'(m * 'h249));
         repeat (40) @(posedge pclk);
         watch(100);
         foreach (hc[i]) begin
            dd = i + 3;
            check(hc[i], m == 2 ? 100 : m == 6 ? 10 * dd : m == 7 ? 10 * dd - 20 : 0);
            check(lc[i], m == 1 ? 100 : m == 5 ? 10 * dd : m == 7 ? 70 - 10 * dd : 0);
         end
      end
      foreach (tc[i]) check(tc[i], i == 4 ? 40 : 20);
      apb(1'h1, FCPWM_CHOP_OFS, 32'hdb6);
      for (int s = 1; s < 4; s++) begin
         phase(s);
         check(d, s == 1 ? 2 : s == 2 ? 6 : 5);
      end
      $display("test modes and triggers done");
      for (int al = 0; al < 3; al++) begin
         apb(1'h1, FCPWM_CFG_OFS, 32'(9 + (al << 12)));
         repeat (40) @(posedge pclk);
         watch(180);
         check(hc[0], al == 1 ? 50 : 54);
         phase(0);
         check(d, al == 0 ? 2 : 9);
         phase(3);
         check(d, al == 1 ? 9 : 5);
      end
      $display("test alignment done");
      apb(1'h1, FCPWM_CFG_OFS, 32'h9);
      apb(1'h1, FCPWM_DUTY_OFS, 32'h0003_0003);
      repeat (40) @(posedge pclk);
      watch(100);
      check(hc[0], 30);
      phase(0);
      check(d, 5);
      $display("test shift done");
      watch_en <= 1'h0;
      apb(1'h1, FCPWM_CFG_OFS, 32'h0001_c009);
      pol <= 3'h7;
      repeat (40) @(posedge pclk);
      watch_en <= 1'h1;
      watch(100);
      check(hc[0], 30);
      check(lso, 32'hf);
      check(tc[0], 80);
      check(shoot, 0);
      $display("test polarity done");
      stop_test();
   end
endmodule

bind fcpwm_top fcpwm_chk #(.NCH(NCH)) chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .high_side_out(high_side_out), .low_side_out(low_side_out),
   .cycle_start_trigger(cycle_start_trigger), .mid_cycle_trigger(mid_cycle_trigger),
   .trigger_a(trigger_a), .trigger_b(trigger_b),
   .combined_programmable_trigger(combined_programmable_trigger)
);
